// ---- pkg/fpt_pkg.sv ----
// Constants and types shared by the flash controller design files
package fpt_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [11:0] FPT_OFF_TARGET_ADDR  = 12'h000;
  localparam logic [11:0] FPT_OFF_WRITE_WORD   = 12'h004;
  localparam logic [11:0] FPT_OFF_CONTROL      = 12'h008;
  localparam logic [11:0] FPT_OFF_RAW_STATUS   = 12'h00C;
  localparam logic [11:0] FPT_OFF_INT_MASK     = 12'h010;
  localparam logic [11:0] FPT_OFF_STATUS_CLEAR = 12'h014;
  localparam logic [11:0] FPT_OFF_READ_EN      = 12'h130;
  localparam logic [11:0] FPT_OFF_PROG_EN      = 12'h134;
  localparam logic [11:0] FPT_OFF_USEC_RELOAD  = 12'h140;

  // Control register fields
  localparam logic [15:0] FPT_WRITE_KEY     = 16'hA442;
  localparam int          FPT_KEY_LSB       = 16;
  localparam int          FPT_BIT_WRITE     = 0;
  localparam int          FPT_BIT_ERASE     = 1;
  localparam int          FPT_BIT_MASS_ERASE_BIT    = 2;
  localparam int          FPT_BIT_COMMIT    = 3;

  // Status and mask fields
  localparam int          FPT_BIT_ACCESS    = 0;
  localparam int          FPT_BIT_PROG_DONE = 1;

  // Commit selector values in the target address register
  localparam logic [31:0] FPT_SEL_READ_EN   = 32'h0000_0000;
  localparam logic [31:0] FPT_SEL_PROG_EN   = 32'h0000_0001;

  // Array geometry: 32 KB modelled, 16 regions of 2 KB (32 region bits), 1 KB pages
  localparam int          FPT_WORD_AW       = 13;
  localparam int          FPT_PAGE_LSB      = 10;
  localparam int          FPT_REGION_LSB    = 11;
  localparam int          FPT_REGIONS       = 32;
  localparam int          FPT_PAGE_WORDS    = 256;

  // Reset values
  localparam logic [31:0] FPT_PROT_RESET    = 32'hFFFF_FFFF;
  localparam logic [7:0]  FPT_USEC_RESET    = 8'h31;

  // Operation timing in microseconds
  localparam int          FPT_PROG_US       = 20;
  localparam int          FPT_ERASE_US      = 2;
  localparam int          FPT_COMMIT_US     = 1;
  localparam logic [7:0]  FPT_PROG_US_W     = 8'(FPT_PROG_US);
  localparam logic [7:0]  FPT_ERASE_US_W    = 8'(FPT_ERASE_US);
  localparam logic [7:0]  FPT_COMMIT_US_W   = 8'(FPT_COMMIT_US);

  typedef enum logic [2:0] {
    FPT_IDLE   = 3'h0,
    FPT_PROG   = 3'h1,
    FPT_ERASE  = 3'h2,
    FPT_MASS_ERASE_BIT = 3'h3,
    FPT_COMMIT = 3'h4
  } fpt_state_t;
endpackage

// ---- verif/fpt_bus_model.sv ----
// Core bus model issuing data reads and instruction fetches
`timescale 1ns/1ps
module fpt_bus_model (
  input  wire logic        clk,
  output logic      [31:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_fetch,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_fault
);
  initial begin
    mem_addr = 32'h0;
    mem_rd = 1'b0;
    mem_fetch = 1'b0;
  end
  task automatic access(input logic fe, input logic [31:0] a, output logic [31:0] d,
                        output logic flt);
    @(posedge clk);
    mem_addr  <= a;
    mem_rd    <= !fe;
    mem_fetch <= fe;
    @(posedge clk);
    mem_rd    <= 1'b0;
    mem_fetch <= 1'b0;
    // Stale address is inverted so nothing relies on it
    mem_addr  <= ~a;
    #1;
    d   = mem_rdata;
    flt = mem_fault;
  endtask
endmodule

// ---- verif/fpt_ctrl_props.sv ----
// Assertion checker for the flash controller ports
`timescale 1ns/1ps
module fpt_ctrl_props
  import fpt_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_fetch,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_fault,
  input wire logic        busy,
  input wire logic        flash_irq
);
  logic [7:0]  usec_q;
  logic [3:0]  op_q;
  logic [1:0]  mask_q;
  logic [15:0] cnt_q;
  wire         ctl_w = reg_wr && reg_addr == FPT_OFF_CONTROL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usec_q <= FPT_USEC_RESET;
      op_q   <= 4'h0;
      mask_q <= 2'h0;
      cnt_q  <= 16'h0;
    end else begin
      if (reg_wr && reg_addr == FPT_OFF_USEC_RELOAD) usec_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == FPT_OFF_INT_MASK) mask_q <= reg_wdata[1:0];
      if (ctl_w && !busy && reg_wdata[31:16] == FPT_WRITE_KEY) op_q <= reg_wdata[3:0];
      cnt_q <= busy ? cnt_q + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_fault;
    mem_fault |-> $past(mem_rd) && mem_rdata == 32'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault without data read");
  property p_fetch;
    mem_fetch && !mem_rd |=> !mem_fault;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch faulted");
  property p_key;
    ctl_w && !busy && reg_wdata[31:16] != FPT_WRITE_KEY |=> !busy;
  endproperty
  a_key: assert property (p_key) else $error("bad key started work");
  property p_ctl;
    reg_rd && reg_addr == FPT_OFF_CONTROL |=> (|reg_rdata[3:0]) == $past(busy);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control bits disagree with busy");
  property p_mask;
    mask_q == 2'h0 |-> !flash_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while fully masked");
  property p_done;
    $fell(busy) && mask_q[1] && !op_q[3] |=> flash_irq;
  endproperty
  a_done: assert property (p_done) else $error("no irq after completion");
  property p_clr;
    reg_wr && reg_addr == FPT_OFF_STATUS_CLEAR && (reg_wdata[1:0] | ~mask_q) == 2'h3 && !busy
      |=> !flash_irq;
  endproperty
  a_clr: assert property (p_clr) else $error("irq survived clear");
  property p_len;
    $fell(busy) && op_q == 4'h1 |-> cnt_q >= 16'd19 * (16'(usec_q) + 16'h1)
      && cnt_q <= 16'd21 * (16'(usec_q) + 16'h1) + 16'h2;
  endproperty
  a_len: assert property (p_len) else $error("program length off");
endmodule
bind fpt_ctrl fpt_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_fetch(mem_fetch), .mem_rdata(mem_rdata),
  .mem_fault(mem_fault), .busy(busy), .flash_irq(flash_irq));

// ---- verif/testbench.sv ----
// Self-checking bench for the flash controller
`timescale 1ns/1ps
module testbench;
  import fpt_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [31:0] reg_rdata, mem_addr, mem_rdata;
  wire         mem_rd, mem_fetch, mem_fault, busy, flash_irq;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] d;
  logic        f;
  always #50 clk = ~clk;
  fpt_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_fetch(mem_fetch), .mem_rdata(mem_rdata), .mem_fault(mem_fault),
    .busy(busy), .flash_irq(flash_irq));
  fpt_bus_model bus (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_fetch(mem_fetch),
    .mem_rdata(mem_rdata), .mem_fault(mem_fault));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task mem(input logic fe, input logic [31:0] a, input logic [31:0] e, input logic ef);
    bus.access(fe, a, d, f);
    chk("mem_rdata", e, d);
    chk("mem_fault", {31'h0, ef}, {31'h0, f});
  endtask
  // Busy is counted; a stuck sequencer runs into the cycle timeout
  task op(input logic [31:0] a, input logic [31:0] w, input logic [3:0] c);
    wr(FPT_OFF_WRITE_WORD, w);
    wr(FPT_OFF_TARGET_ADDR, a);
    wr(FPT_OFF_CONTROL, {FPT_WRITE_KEY, 12'h0, c});
    #1 n = 0;
    while (busy === 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task t_reset;
    rc("read_en", FPT_OFF_READ_EN, 32'hFFFF_FFFF);
    rc("prog_en", FPT_OFF_PROG_EN, 32'hFFFF_FFFF);
    rc("usec", FPT_OFF_USEC_RELOAD, 32'h31);
    rc("raw", FPT_OFF_RAW_STATUS, 32'h0);
    wr(12'h0FC, 32'hFFFF_FFFF);
    rc("unmapped", 12'h0FC, 32'h0);
  endtask
  task t_prog;
    wr(FPT_OFF_USEC_RELOAD, 32'h1);
    wr(FPT_OFF_INT_MASK, 32'h2);
    op(32'h0, 32'h0, 4'h4);
    chk("mass_erase_bit_len", 32'h1, 32'(n > 8192));
    mem(0, 32'h7FFC, 32'hFFFF_FFFF, 0);
    op(32'h0, 32'h0, 4'h2);
    mem(0, 32'h3FC, 32'hFFFF_FFFF, 0);
    op(32'h0, 32'hA5A5_0F0F, 4'h1);
    chk("prog_cycles", 32'h1, 32'(n >= 38 && n <= 42));
    rc("control", FPT_OFF_CONTROL, 32'h0);
    chk("irq", 32'h1, {31'h0, flash_irq});
    op(32'h0, 32'hFFFF_00FF, 4'h1);
    mem(0, 32'h0, 32'hA5A5_000F, 0);
    op(32'h400, 32'h0, 4'h2);
    mem(0, 32'h0, 32'hA5A5_000F, 0);
    rc("raw", FPT_OFF_RAW_STATUS, 32'h2);
    wr(FPT_OFF_STATUS_CLEAR, 32'h2);
    rc("raw", FPT_OFF_RAW_STATUS, 32'h0);
  endtask
  task t_protect;
    wr(FPT_OFF_INT_MASK, 32'h0);
    op(32'h800, 32'h0, 4'h2);
    wr(FPT_OFF_STATUS_CLEAR, 32'h3);
    wr(FPT_OFF_PROG_EN, 32'hFFFF_FFFD);
    wr(FPT_OFF_PROG_EN, 32'hFFFF_FFFF);
    rc("prog_en", FPT_OFF_PROG_EN, 32'hFFFF_FFFD);
    op(32'h800, 32'h0, 4'h1);
    chk("refused", 32'h0, n);
    rc("raw", FPT_OFF_RAW_STATUS, 32'h1);
    rc("masked", FPT_OFF_STATUS_CLEAR, 32'h0);
    wr(FPT_OFF_INT_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h1, {31'h0, flash_irq});
    wr(FPT_OFF_STATUS_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, flash_irq});
    op(32'hC00, 32'h0, 4'h2);
    rc("raw", FPT_OFF_RAW_STATUS, 32'h1);
    mem(0, 32'h800, 32'hFFFF_FFFF, 0);
    op(32'h0, 32'h0, 4'h4);
    chk("mass_erase_bit", 32'h0, n);
    mem(0, 32'h0, 32'hA5A5_000F, 0);
    wr(FPT_OFF_READ_EN, 32'hFFFF_FFFD);
    mem(0, 32'h800, 32'h0, 1);
    mem(1, 32'h800, 32'hFFFF_FFFF, 0);
    mem(0, 32'h0, 32'hA5A5_000F, 0);
    wr(FPT_OFF_CONTROL, 32'hA443_0002);
    #1 chk("busy", 32'h0, {31'h0, busy});
    mem(0, 32'h0, 32'hA5A5_000F, 0);
    op(FPT_SEL_PROG_EN, 32'h0, 4'h8);
    rc("control", FPT_OFF_CONTROL, 32'h0);
    reset();
    rc("read_en", FPT_OFF_READ_EN, 32'hFFFF_FFFF);
    rc("prog_en", FPT_OFF_PROG_EN, 32'hFFFF_FFFD);
  endtask
  task results;
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    reset();
    t_reset();
    t_prog();
    t_protect();
    results();
  end
endmodule

// ---- verilog/fpt_array.sv ----
// Flash array model: word storage with AND-program and page or whole erase
`timescale 1ns/1ps
module fpt_array
  import fpt_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [FPT_WORD_AW-1:0] rd_addr,
  output logic      [31:0]            rd_data,
  input  wire logic                   prog_en,
  input  wire logic [FPT_WORD_AW-1:0] prog_addr,
  input  wire logic [31:0]            prog_data,
  input  wire logic                   erase_en,
  input  wire logic [FPT_WORD_AW-1:0] erase_idx,
  input  wire logic                   erase_all
);
  localparam int WORDS = 1 << FPT_WORD_AW;
  localparam int PAGE_W = FPT_PAGE_LSB - 2;
  logic [31:0] mem [WORDS];

  assign rd_data = mem[rd_addr];

  // Erase walks one word per clock; no reset, contents are nonvolatile
  always_ff @(posedge clk) begin
    if (prog_en) begin
      mem[prog_addr] <= mem[prog_addr] & prog_data;
    end
    if (erase_en) begin
      if (erase_all) begin
        mem[erase_idx] <= 32'hFFFF_FFFF;
      end else begin
        mem[{prog_addr[FPT_WORD_AW-1:PAGE_W], erase_idx[PAGE_W-1:0]}] <= 32'hFFFF_FFFF;
      end
    end
  end
endmodule

// ---- verilog/fpt_ctrl.sv ----
// Flash controller: registers, protection, timed program and erase sequencer
//
// Notes on behaviour
// - Page erase sets every bit to one
// - Word program only clears bits
// - One program and read bit per 2 KB
// - Program-enable zero blocks program and erase
// - Read-enable zero forbids data reads
// - Both zero: fetch only, no change
// - Protected data read answers bus fault
// - Protected program sets access status bit
// - Bits only clear; commit makes permanent
// - Uncommitted clears revert at power-on reset
// - Timing counts from microsecond reload value
// - Program or erase completion sets programming-done status
// - Masked status gates the interrupt output
// - Raw status always readable
// - Writing one clears status bit
// - Keyed write bit programs, self-clears
// - Keyed erase bit erases page, self-clears
// - Keyed mass-erase bit erases all, self-clears
// - Keyed commit bit saves protection, self-clears
`timescale 1ns/1ps
module fpt_ctrl
  import fpt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_fetch,
  output logic      [31:0] mem_rdata,
  output logic             mem_fault,
  output logic             busy,
  output logic             flash_irq
);
  localparam int PAGE_W = FPT_PAGE_LSB - 2;
  localparam int RW     = $clog2(FPT_REGIONS);

  typedef struct packed {
    fpt_state_t           state;
    logic [31:0]          target;
    logic [31:0]          wword;
    logic [3:0]           ctl;
    logic [1:0]           raw;
    logic [1:0]           mask;
    logic [7:0]           usec;
    logic [7:0]           us_div;
    logic [7:0]           us_left;
    logic [FPT_WORD_AW-1:0] idx;
    logic [31:0]          rd_live;
    logic [31:0]          pg_live;
    logic [31:0]          rdata;
    logic [31:0]          mdata;
    logic                 fault;
    logic                 irq;
    logic                 busy;
  } fpt_regs_t;

  fpt_regs_t q;
  fpt_regs_t d;

  logic [31:0]            arr_rd;
  logic                   arr_prog;
  logic                   arr_erase;
  logic                   arr_all;
  logic [FPT_WORD_AW-1:0] tgt_word;
  logic [FPT_WORD_AW-1:0] rd_word;
  logic [RW-1:0]          tgt_region;
  logic [RW-1:0]          rd_region;
  logic                   key_ok;
  logic                   us_tick;
  logic                   done;
  // Factory state of the nonvolatile protection cells is all ones
  logic [31:0]            rd_saved_q = FPT_PROT_RESET;
  logic [31:0]            pg_saved_q = FPT_PROT_RESET;
  logic [31:0]            rd_saved_d;
  logic [31:0]            pg_saved_d;
  logic [31:0]            rd_eff;
  logic [31:0]            pg_eff;

  assign tgt_word   = q.target[FPT_WORD_AW+1:2];
  assign rd_word    = mem_addr[FPT_WORD_AW+1:2];
  // Region taken from the word index, so aliased addresses cannot dodge protection
  assign tgt_region = RW'(tgt_word[FPT_WORD_AW-1:FPT_REGION_LSB-2]);
  assign rd_region  = RW'(rd_word[FPT_WORD_AW-1:FPT_REGION_LSB-2]);
  // Committed clears stay in effect across every reset
  assign rd_eff     = q.rd_live & rd_saved_q;
  assign pg_eff     = q.pg_live & pg_saved_q;
  assign key_ok     = reg_wdata[31:FPT_KEY_LSB] == FPT_WRITE_KEY;
  assign us_tick    = (q.us_div == 8'h00);

  fpt_array u_array (
    .clk       (clk),
    .rd_addr   (rd_word),
    .rd_data   (arr_rd),
    .prog_en   (arr_prog),
    .prog_addr (tgt_word),
    .prog_data (q.wword),
    .erase_en  (arr_erase),
    .erase_idx (q.idx),
    .erase_all (arr_all)
  );

  always_comb begin
    d         = q;
    arr_prog  = 1'b0;
    arr_erase = 1'b0;
    arr_all   = 1'b0;
    done      = 1'b0;
    rd_saved_d = rd_saved_q;
    pg_saved_d = pg_saved_q;

    // Microsecond prescaler free-runs from the reload value
    if (us_tick) begin
      d.us_div = q.usec;
      if (q.us_left != 8'h00) begin
        d.us_left = q.us_left - 8'h01;
      end
    end else begin
      d.us_div = q.us_div - 8'h01;
    end

    case (q.state)
      FPT_IDLE: begin
      end
      FPT_PROG: begin
        if (us_tick && q.us_left == 8'h00) begin
          arr_prog = 1'b1;
          done     = 1'b1;
        end
      end
      FPT_ERASE: begin
        if (q.us_left == 8'h00) begin
          arr_erase = 1'b1;
          d.idx     = q.idx + 1'b1;
          if (q.idx[PAGE_W-1:0] == PAGE_W'(FPT_PAGE_WORDS - 1)) begin
            done = 1'b1;
          end
        end
      end
      FPT_MASS_ERASE_BIT: begin
        if (q.us_left == 8'h00) begin
          arr_erase = 1'b1;
          arr_all   = 1'b1;
          d.idx     = q.idx + 1'b1;
          if (&q.idx) begin
            done = 1'b1;
          end
        end
      end
      FPT_COMMIT: begin
        if (us_tick && q.us_left == 8'h00) begin
          done = 1'b1;
          // Only the live bits that cleared are saved; saved bits never rise
          if (q.target == FPT_SEL_READ_EN) begin
            rd_saved_d = rd_saved_q & q.rd_live;
          end else if (q.target == FPT_SEL_PROG_EN) begin
            pg_saved_d = pg_saved_q & q.pg_live;
          end
        end
      end
      default: begin
        d.state = FPT_IDLE;
      end
    endcase

    if (done) begin
      d.state = FPT_IDLE;
      d.ctl   = 4'h0;
      if (q.state != FPT_COMMIT) begin
        d.raw[FPT_BIT_PROG_DONE] = 1'b1;
      end
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        FPT_OFF_TARGET_ADDR: begin
          if (q.state == FPT_IDLE) begin
            d.target = reg_wdata;
          end
        end
        FPT_OFF_WRITE_WORD: begin
          if (q.state == FPT_IDLE) begin
            d.wword = reg_wdata;
          end
        end
        FPT_OFF_CONTROL: begin
          if (key_ok && q.state == FPT_IDLE) begin
            d.idx     = '0;
            d.us_left = FPT_PROG_US_W;
            if (reg_wdata[FPT_BIT_WRITE] || reg_wdata[FPT_BIT_ERASE]) begin
              if (!pg_eff[tgt_region]) begin
                d.raw[FPT_BIT_ACCESS] = 1'b1;
              end else if (reg_wdata[FPT_BIT_WRITE]) begin
                d.state = FPT_PROG;
                d.ctl   = 4'h1 << FPT_BIT_WRITE;
              end else begin
                d.state   = FPT_ERASE;
                d.ctl     = 4'h1 << FPT_BIT_ERASE;
                d.us_left = FPT_ERASE_US_W;
                d.idx     = {tgt_word[FPT_WORD_AW-1:PAGE_W], PAGE_W'(0)};
              end
            end else if (reg_wdata[FPT_BIT_MASS_ERASE_BIT]) begin
              if (&pg_eff) begin
                d.state   = FPT_MASS_ERASE_BIT;
                d.ctl     = 4'h1 << FPT_BIT_MASS_ERASE_BIT;
                d.us_left = FPT_ERASE_US_W;
              end else begin
                d.raw[FPT_BIT_ACCESS] = 1'b1;
              end
            end else if (reg_wdata[FPT_BIT_COMMIT]) begin
              d.state   = FPT_COMMIT;
              d.ctl     = 4'h1 << FPT_BIT_COMMIT;
              d.us_left = FPT_COMMIT_US_W;
            end
          end
        end
        FPT_OFF_INT_MASK: begin
          d.mask = reg_wdata[1:0];
        end
        FPT_OFF_STATUS_CLEAR: begin
          // Clear loses to a same-cycle set from the logic above
          d.raw = d.raw & ~(reg_wdata[1:0] & ~(d.raw & ~q.raw));
        end
        FPT_OFF_READ_EN: begin
          d.rd_live = q.rd_live & reg_wdata;
        end
        FPT_OFF_PROG_EN: begin
          d.pg_live = q.pg_live & reg_wdata;
        end
        FPT_OFF_USEC_RELOAD: begin
          d.usec = reg_wdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data one cycle later
    d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        FPT_OFF_TARGET_ADDR:  d.rdata = q.target;
        FPT_OFF_WRITE_WORD:   d.rdata = q.wword;
        FPT_OFF_CONTROL:      d.rdata = {28'h0, q.ctl};
        FPT_OFF_RAW_STATUS:   d.rdata = {30'h0, q.raw};
        FPT_OFF_INT_MASK:     d.rdata = {30'h0, q.mask};
        FPT_OFF_STATUS_CLEAR: d.rdata = {30'h0, q.raw & q.mask};
        FPT_OFF_READ_EN:      d.rdata = rd_eff;
        FPT_OFF_PROG_EN:      d.rdata = pg_eff;
        FPT_OFF_USEC_RELOAD:  d.rdata = {24'h0, q.usec};
        default:              d.rdata = 32'h0000_0000;
      endcase
    end

    // Memory port: fetches pass, data reads need read-enable
    d.mdata = 32'h0000_0000;
    d.fault = 1'b0;
    if (mem_rd || mem_fetch) begin
      if (mem_fetch || rd_eff[rd_region]) begin
        d.mdata = arr_rd;
      end else begin
        d.fault = 1'b1;
      end
    end

    d.irq = |(d.raw & d.mask);
    // Busy is registered so the output comes straight from a flop
    d.busy = (d.state != FPT_IDLE);
  end

  // Power-on reset reloads saved protection; uncommitted clears are lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.state    <= FPT_IDLE;
      q.usec     <= FPT_USEC_RESET;
      q.us_div   <= FPT_USEC_RESET;
      q.rd_live  <= FPT_PROT_RESET;
      q.pg_live  <= FPT_PROT_RESET;
    end else begin
      q <= d;
    end
  end

  // No reset: committed bits model nonvolatile cells that survive power cycling
  always_ff @(posedge clk) begin
    rd_saved_q <= rd_saved_d;
    pg_saved_q <= pg_saved_d;
  end

  assign reg_rdata = q.rdata;
  assign mem_rdata = q.mdata;
  assign mem_fault = q.fault;
  assign busy      = q.busy;
  assign flash_irq = q.irq;
endmodule
